// *** core/autoreload_pwm_capture_timer.sv ***
// The implementer's own choice: the Avalon-MM slave port.
`timescale 1ns/1ps
`include "art_regs.svh"

module autoreload_pwm_capture_timer
(
  // Clock and reset
  input  wire logic          ref_clk,
  input  wire logic          rst,
  // Avalon-MM slave
  input  wire art_pkg::addr_t address,
  input  wire logic          read,
  input  wire logic          write,
  input  wire art_pkg::word_t writedata,
  input  wire logic [3:0]    byteenable,
  output art_pkg::word_t     readdata,
  output logic               waitrequest,
  // External count clock
  input  wire logic          ext_clk_in,
  // Capture inputs
  input  wire logic [1:0]    capture_pin,
  // Pulse outputs
  output logic [1:0]         pulse_out_pin,
  output logic [1:0]         pulse_out_oe,
  // Requests
  output logic               overflow_irq,
  output logic [1:0]         capture_irq
);
  import art_pkg::*;

  // Bus handshake
  logic                      bus_ack;
  logic                      bus_take;
  logic                      rd_take;
  logic                      wr_take;
  byte_t                     wbyte;
  // Control
  logic                      external_clock_select;
  tap_t                      prescale_tap_select;
  logic                      count_run_enable;
  logic                      overflow_irq_enable;
  logic                      overflow_flag;
  logic [1:0]                output_polarity;
  logic [1:0]                output_enable;
  logic [1:0]                capture_sense;
  logic [1:0]                capture_irq_enable;
  byte_t                     reload_value;
  byte_t                     duty_value [2];
  byte_t                     compare_shadow [2];
  // Counting
  byte_t                     counter;
  presc_t                    prescaler;
  presc_t                    tap_mask;
  logic                      ext_prev;
  logic                      input_tick;
  logic                      count_tick;
  logic                      wrap;
  logic                      force_reload;
  logic                      counter_write;
  logic [1:0]                pulse_level;
  // Capture side
  logic [1:0]                capture_event_flag;
  byte_t                     capture_value [2];
  logic [1:0]                capture_read;
  byte_t                     next_rdata;
  // Decoded register strobes
  logic                      wr_duty0;
  logic                      wr_duty1;
  logic                      wr_pwm_ctrl;
  logic                      wr_timer_cs;
  logic                      wr_counter;
  logic                      wr_reload;
  logic                      wr_capture_cs;
  logic                      rd_timer_cs;
  logic                      soft_load;

  function automatic logic reg_hit(input addr_t addr, input byte_t idx);
    reg_hit = (addr[9:2] == idx) && (addr[1:0] == 2'b00);
  endfunction

  // One wait state gives read data a full cycle to settle
  assign waitrequest = (read | write) & ~bus_ack;
  assign bus_take    = (read | write) & bus_ack;
  // Read side effects land on the edge that latches read data, so an event there is kept
  assign rd_take     = read & ~bus_ack;
  assign wr_take     = write & bus_take & byteenable[0];
  assign wbyte       = writedata[7:0];

  // Each strobe is decoded once and shared by data, prescaler and flag logic
  assign wr_duty0      = wr_take && reg_hit(address, `ART_IDX_DUTY0);
  assign wr_duty1      = wr_take && reg_hit(address, `ART_IDX_DUTY1);
  assign wr_pwm_ctrl   = wr_take && reg_hit(address, `ART_IDX_PWM_CTRL);
  assign wr_timer_cs   = wr_take && reg_hit(address, `ART_IDX_TIMER_CS);
  assign wr_counter    = wr_take && reg_hit(address, `ART_IDX_COUNTER);
  assign wr_reload     = wr_take && reg_hit(address, `ART_IDX_RELOAD);
  assign wr_capture_cs = wr_take && reg_hit(address, `ART_IDX_CAPTURE_CS);
  assign rd_timer_cs   = rd_take && reg_hit(address, `ART_IDX_TIMER_CS);

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      bus_ack <= 1'b0;
    else
      bus_ack <= (read | write) & ~bus_ack;
  end

  always_comb
  begin
    next_rdata = `ART_RESET_BYTE;
    if (reg_hit(address, `ART_IDX_DUTY1))
      next_rdata = duty_value[1];
    else if (reg_hit(address, `ART_IDX_DUTY0))
      next_rdata = duty_value[0];
    else if (reg_hit(address, `ART_IDX_PWM_CTRL))
      next_rdata = {2'b00, output_enable, 2'b00, output_polarity};
    else if (reg_hit(address, `ART_IDX_TIMER_CS))
      next_rdata = {external_clock_select, prescale_tap_select, count_run_enable,
                    1'b0, overflow_irq_enable, overflow_flag};
    else if (reg_hit(address, `ART_IDX_COUNTER))
      next_rdata = counter;
    else if (reg_hit(address, `ART_IDX_RELOAD))
      next_rdata = reload_value;
    else if (reg_hit(address, `ART_IDX_CAPTURE_CS))
      next_rdata = {2'b00, capture_sense, capture_irq_enable, capture_event_flag};
    else if (reg_hit(address, `ART_IDX_CAPTURE1))
      next_rdata = capture_value[0];
    else if (reg_hit(address, `ART_IDX_CAPTURE2))
      next_rdata = capture_value[1];
  end

  // Unmapped addresses read zero and ignore writes
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      readdata <= 32'h0000_0000;
    else if (rd_take)
      readdata <= {24'h00_0000, next_rdata};
  end

  // Control registers
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      external_clock_select <= 1'b0;
      prescale_tap_select   <= 3'h0;
      count_run_enable      <= 1'b0;
      overflow_irq_enable   <= 1'b0;
    end
    else if (wr_timer_cs)
    begin
      external_clock_select <= wbyte[`ART_CS_EXT_CLK_BIT];
      prescale_tap_select   <= wbyte[`ART_CS_TAP_HI:`ART_CS_TAP_LO];
      count_run_enable      <= wbyte[`ART_CS_RUN_BIT];
      overflow_irq_enable   <= wbyte[`ART_CS_OVF_IE_BIT];
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      output_polarity <= 2'b00;
      output_enable   <= 2'b00;
    end
    else if (wr_pwm_ctrl)
    begin
      output_polarity <= wbyte[`ART_PC_POL_LO +: 2];
      output_enable   <= wbyte[`ART_PC_OE_LO +: 2];
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      capture_sense      <= 2'b00;
      capture_irq_enable <= 2'b00;
    end
    else if (wr_capture_cs)
    begin
      capture_sense      <= wbyte[`ART_CC_SENSE_LO +: 2];
      capture_irq_enable <= wbyte[`ART_CC_IE_LO +: 2];
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      reload_value <= `ART_RESET_BYTE;
    else if (wr_reload)
      reload_value <= wbyte;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      duty_value[0] <= `ART_RESET_BYTE;
      duty_value[1] <= `ART_RESET_BYTE;
    end
    else
    begin
      if (wr_duty0)
        duty_value[0] <= wbyte;
      if (wr_duty1)
        duty_value[1] <= wbyte;
    end
  end

  // Clock source and prescaler
  assign force_reload  = wr_timer_cs && wbyte[`ART_CS_FORCE_BIT];
  assign counter_write = wr_counter;
  assign soft_load     = force_reload | counter_write;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      ext_prev <= 1'b0;
    else
      ext_prev <= ext_clk_in;
  end

  // External clock counts on its rising edge, so it must stay below half the system rate
  assign input_tick = external_clock_select ? (ext_clk_in & ~ext_prev) : 1'b1;
  assign tap_mask   = 7'((8'h01 << prescale_tap_select) - 8'h01);
  assign count_tick = count_run_enable && input_tick && ((prescaler & tap_mask) == tap_mask);
  // A software load in the same cycle wins, so that tick is not an overflow
  assign wrap       = count_tick && (counter == `ART_COUNT_TOP) && !soft_load;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      prescaler <= `ART_PRESC_RESET;
    else if (soft_load)
      prescaler <= `ART_PRESC_RESET;
    else if (count_run_enable && input_tick)
      prescaler <= prescaler + 7'h01;
  end

  // Software load takes priority over a count in the same cycle
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      counter <= `ART_RESET_BYTE;
    else if (counter_write)
      counter <= wbyte;
    else if (force_reload)
      counter <= reload_value;
    else if (wrap)
      counter <= reload_value;
    else if (count_tick)
      counter <= counter + 8'h01;
  end

  // Set wins over the read clear
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      overflow_flag <= 1'b0;
    else if (wrap)
      overflow_flag <= 1'b1;
    else if (rd_timer_cs)
      overflow_flag <= 1'b0;
  end

  assign overflow_irq = overflow_flag & overflow_irq_enable;

  // Pulse channels
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++)
    begin : gen_pwm
      // Double buffering keeps a duty change from glitching mid-period
      always_ff @(posedge ref_clk or posedge rst)
      begin
        if (rst)
          compare_shadow[ch] <= `ART_RESET_BYTE;
        else if (wrap)
          compare_shadow[ch] <= duty_value[ch];
      end

      // Level is recomputed each cycle, so polarity acts without waiting for overflow
      always_ff @(posedge ref_clk or posedge rst)
      begin
        if (rst)
          pulse_level[ch] <= 1'b0;
        else
          pulse_level[ch] <= (counter <= compare_shadow[ch]) ^ output_polarity[ch];
      end

      assign pulse_out_pin[ch] = pulse_level[ch] & output_enable[ch];
      assign pulse_out_oe[ch]  = output_enable[ch];
    end
  endgenerate

  // Capture channels
  assign capture_read[0] = rd_take && reg_hit(address, `ART_IDX_CAPTURE1);
  assign capture_read[1] = rd_take && reg_hit(address, `ART_IDX_CAPTURE2);

  generate
    for (ch = 0; ch < 2; ch++)
    begin : gen_cap
      capture_if cap_bus ();

      assign cap_bus.sense      = capture_sense[ch];
      assign cap_bus.pin        = capture_pin[ch];
      assign cap_bus.count      = counter;
      assign cap_bus.read_clear = capture_read[ch];
      assign capture_event_flag[ch] = cap_bus.flag;
      assign capture_value[ch]      = cap_bus.value;
      assign capture_irq[ch]        = cap_bus.flag & capture_irq_enable[ch];

      capture_channel u_capture
      (
        .ref_clk (ref_clk),
        .rst     (rst),
        .cap     (cap_bus.chan)
      );
    end
  endgenerate
endmodule

// *** include/art_regs.svh ***
`ifndef ART_REGS_SVH
`define ART_REGS_SVH

// Register indices; byte address is four times the index
`define ART_IDX_DUTY1        8'h74
`define ART_IDX_DUTY0        8'h75
`define ART_IDX_PWM_CTRL     8'h76
`define ART_IDX_TIMER_CS     8'h77
`define ART_IDX_COUNTER      8'h78
`define ART_IDX_RELOAD       8'h79
`define ART_IDX_CAPTURE_CS   8'h7a
`define ART_IDX_CAPTURE1     8'h7b
`define ART_IDX_CAPTURE2     8'h7c

// Timer control/status fields
`define ART_CS_EXT_CLK_BIT   7
`define ART_CS_TAP_HI        6
`define ART_CS_TAP_LO        4
`define ART_CS_RUN_BIT       3
`define ART_CS_FORCE_BIT     2
`define ART_CS_OVF_IE_BIT    1
`define ART_CS_OVF_BIT       0

// Pulse output control fields
`define ART_PC_OE_LO         4
`define ART_PC_POL_LO        0

// Capture control/status fields
`define ART_CC_SENSE_LO      4
`define ART_CC_IE_LO         2
`define ART_CC_FLAG_LO       0

// Reset values and counter top
`define ART_RESET_BYTE       8'h00
`define ART_COUNT_TOP        8'hff
`define ART_PRESC_RESET      7'h00

`endif

// *** include/art_pkg.sv ***
package art_pkg;
  typedef logic [7:0]  byte_t;
  typedef logic [31:0] word_t;
  typedef logic [9:0]  addr_t;
  typedef logic [6:0]  presc_t;
  typedef logic [2:0]  tap_t;
endpackage

// *** include/capture_if.sv ***
`timescale 1ns/1ps
interface capture_if;
  logic               sense;
  logic               pin;
  logic [7:0]         count;
  logic               read_clear;
  logic               flag;
  logic [7:0]         value;
  modport ctrl (output sense, output pin, output count, output read_clear, input flag, input value);
  modport chan (input sense, input pin, input count, input read_clear, output flag, output value);
endinterface

// *** core/capture_channel.sv ***
`timescale 1ns/1ps
`include "art_regs.svh"
module capture_channel
(
  // Clock and reset
  input  wire logic   ref_clk,
  input  wire logic   rst,
  // Channel link
  capture_if.chan     cap
);
  import art_pkg::*;

  logic               pin_prev;
  logic               edge_seen;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      pin_prev <= 1'b0;
    else
      pin_prev <= cap.pin;
  end

  // Edge polarity follows the sense bit
  assign edge_seen = cap.sense ? (cap.pin & ~pin_prev) : (~cap.pin & pin_prev);

  // Set wins over the read clear so a capture in the clearing cycle survives
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      cap.flag <= 1'b0;
    else if (edge_seen)
      cap.flag <= 1'b1;
    else if (cap.read_clear)
      cap.flag <= 1'b0;
  end

  // A pending capture blocks new data until software has read it
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      cap.value <= `ART_RESET_BYTE;
    else if (edge_seen && (!cap.flag || cap.read_clear))
      cap.value <= cap.count;
  end
endmodule

// *** verif/art_sva.sv ***
`timescale 1ns/1ps
`include "art_regs.svh"
module art_sva
(
  // Clock and reset
  input wire logic           ref_clk,
  input wire logic           rst,
  // Bus
  input wire art_pkg::addr_t address,
  input wire logic           read,
  input wire logic           write,
  input wire art_pkg::word_t readdata,
  input wire logic           waitrequest,
  // Pins and requests
  input wire logic [1:0]     pulse_out_pin,
  input wire logic [1:0]     pulse_out_oe,
  input wire logic           overflow_irq,
  input wire logic [1:0]     capture_irq
);
  import art_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire acc = read & ~waitrequest;
  wire cs  = acc & (address == {`ART_IDX_TIMER_CS, 2'b00});
  wire cc  = acc & (address == {`ART_IDX_CAPTURE_CS, 2'b00});
  wire c1  = acc & (address == {`ART_IDX_CAPTURE1, 2'b00});
  property p_wait; (read | write) & waitrequest |=> !waitrequest; endproperty
  a_wait: assert property (p_wait) else $error("no answer after one wait");
  property p_idle; !(read | write) |-> !waitrequest; endproperty
  a_idle: assert property (p_idle) else $error("wait while idle");
  property p_hi; acc |-> readdata[31:8] == 24'h0; endproperty
  a_hi: assert property (p_hi) else $error("upper read bits set");
  property p_force; cs |-> !readdata[`ART_CS_FORCE_BIT]; endproperty
  a_force: assert property (p_force) else $error("force bit read as one");
  // Read data is latched one cycle before acceptance, so compare with the past request
  property p_ovirq; cs |-> $past(overflow_irq) == (readdata[0] & readdata[1]); endproperty
  a_ovirq: assert property (p_ovirq) else $error("overflow request mismatch");
  property p_capirq; cc |-> $past(capture_irq) == (readdata[1:0] & readdata[3:2]); endproperty
  a_capirq: assert property (p_capirq) else $error("capture request mismatch");
  property p_rsv; cc |-> readdata[7:6] == 2'b00; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits set");
  property p_clr; c1 |=> !capture_irq[0]; endproperty
  a_clr: assert property (p_clr) else $error("capture flag not cleared");
  property p_oe; (pulse_out_pin & ~pulse_out_oe) == 2'b00; endproperty
  a_oe: assert property (p_oe) else $error("disabled output driven");
  property p_rst; $fell(rst) |-> readdata == 32'h0 && pulse_out_pin == 2'b00 && !overflow_irq; endproperty
  a_rst: assert property (p_rst) else $error("nonzero after reset");
  c_ovf: cover property (cs && readdata[0]);
  c_cap: cover property (c1);
  c_pwm: cover property ($rose(pulse_out_pin[1]));
endmodule
bind autoreload_pwm_capture_timer art_sva u_sva (.ref_clk(ref_clk), .rst(rst), .address(address),
  .read(read), .write(write), .readdata(readdata), .waitrequest(waitrequest),
  .pulse_out_pin(pulse_out_pin), .pulse_out_oe(pulse_out_oe), .overflow_irq(overflow_irq),
  .capture_irq(capture_irq));

// *** verif/autoreload_pwm_capture_timer_tb_top.sv ***
`timescale 1ns/1ps
`include "art_regs.svh"
module autoreload_pwm_capture_timer_tb_top;
  import art_pkg::*;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  addr_t       address = '0;
  logic        read = 1'b0;
  logic        write = 1'b0;
  word_t       writedata = '0;
  logic [3:0]  byteenable = 4'hf;
  word_t       readdata;
  logic        waitrequest;
  logic        ext_clk_in = 1'b0;
  logic [1:0]  capture_pin = 2'b00;
  logic [1:0]  pulse_out_pin;
  logic [1:0]  pulse_out_oe;
  logic        overflow_irq;
  logic [1:0]  capture_irq;
  int          fail_count = 0;
  int          cmp_count = 0;
  int          n;
  int          h0;
  int          h1;
  logic        p;
  // Reload, duty and expected high counts over 256 cycles
  byte_t       cfg [2][3] = '{'{8'h00, 8'h40, 8'h80}, '{8'hc0, 8'he0, 8'h80}};
  int          exh [2][2] = '{'{65, 127}, '{132, 256}};
  always #2 ref_clk = ~ref_clk;
  autoreload_pwm_capture_timer DUT (.ref_clk(ref_clk), .rst(rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .ext_clk_in(ext_clk_in), .capture_pin(capture_pin),
    .pulse_out_pin(pulse_out_pin), .pulse_out_oe(pulse_out_oe), .overflow_irq(overflow_irq),
    .capture_irq(capture_irq));
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e)
    begin
      $display("[ERR] %0t got %h exp %h", $time, g, e);
      fail_count++;
    end
  endtask
  // One access: held until waitrequest is seen low, then one idle cycle
  task automatic acc(input logic w, input byte_t idx, input byte_t d, output byte_t q);
    int k;
    k = 0;
    address <= {idx, 2'b00};
    writedata <= {24'h0, d};
    if (w) write <= 1'b1;
    else read <= 1'b1;
    @(posedge ref_clk);
    while (waitrequest !== 1'b0 && k < 20)
    begin
      @(posedge ref_clk);
      k++;
    end
    q = readdata[7:0];
    read <= 1'b0;
    write <= 1'b0;
    if (k == 20)
    begin
      $display("[ERR] %0t bus timeout", $time);
      fail_count++;
      report_and_stop();
    end
    @(posedge ref_clk);
  endtask
  task automatic wr(input byte_t idx, input byte_t d);
    byte_t q;
    acc(1'b1, idx, d, q);
  endtask
  task automatic rc(input byte_t idx, input byte_t e);
    byte_t q;
    acc(1'b0, idx, 8'h00, q);
    chk(q, e);
  endtask
  initial
  begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    for (int i = 8'h74; i <= 8'h7c; i++) rc(byte_t'(i), 8'h00);
    wr(8'h7f, 8'hff);
    rc(8'h7f, 8'h00);
    byteenable <= 4'h0;
    wr(`ART_IDX_DUTY1, 8'h11);
    byteenable <= 4'hf;
    rc(`ART_IDX_DUTY1, 8'h00);
    wr(`ART_IDX_PWM_CTRL, 8'hff);
    rc(`ART_IDX_PWM_CTRL, 8'h33);
    chk(pulse_out_oe, 2'b11);
    $display("registers done");
    wr(`ART_IDX_RELOAD, 8'h3c);
    wr(`ART_IDX_TIMER_CS, 8'h04);
    rc(`ART_IDX_COUNTER, 8'h3c);
    repeat (10) @(posedge ref_clk);
    rc(`ART_IDX_COUNTER, 8'h3c);
    wr(`ART_IDX_COUNTER, 8'h80);
    rc(`ART_IDX_COUNTER, 8'h80);
    wr(`ART_IDX_RELOAD, 8'h00);
    wr(`ART_IDX_TIMER_CS, 8'h8c);
    repeat (5)
    begin
      ext_clk_in <= 1'b1;
      repeat (3) @(posedge ref_clk);
      ext_clk_in <= 1'b0;
      repeat (3) @(posedge ref_clk);
    end
    wr(`ART_IDX_TIMER_CS, 8'h80);
    rc(`ART_IDX_COUNTER, 8'h05);
    $display("counter done");
    // Divide by 128 keeps the two-count period long enough to read the flag twice
    wr(`ART_IDX_RELOAD, 8'hfe);
    wr(`ART_IDX_TIMER_CS, 8'h7e);
    n = 0;
    while (overflow_irq !== 1'b1 && n < 400)
    begin
      @(posedge ref_clk);
      n++;
    end
    chk(n > 249 && n < 261, 1'b1);
    if (n == 400)
      report_and_stop();
    rc(`ART_IDX_TIMER_CS, 8'h7b);
    rc(`ART_IDX_TIMER_CS, 8'h7a);
    wr(`ART_IDX_TIMER_CS, 8'h78);
    repeat (300) @(posedge ref_clk);
    chk(overflow_irq, 1'b0);
    rc(`ART_IDX_TIMER_CS, 8'h79);
    $display("overflow done");
    wr(`ART_IDX_PWM_CTRL, 8'h31);
    for (int c = 0; c < 2; c++)
    begin
      wr(`ART_IDX_RELOAD, cfg[c][0]);
      wr(`ART_IDX_DUTY1, cfg[c][1]);
      wr(`ART_IDX_DUTY0, cfg[c][2]);
      wr(`ART_IDX_TIMER_CS, 8'h0c);
      repeat (300) @(posedge ref_clk);
      h0 = 0;
      h1 = 0;
      repeat (256)
      begin
        @(negedge ref_clk);
        h0 += pulse_out_pin[0];
        h1 += pulse_out_pin[1];
      end
      chk(16'(h1), 16'(exh[c][0]));
      chk(16'(h0), 16'(exh[c][1]));
      @(posedge ref_clk);
    end
    wr(`ART_IDX_TIMER_CS, 8'h00);
    @(negedge ref_clk);
    p = pulse_out_pin[1];
    @(posedge ref_clk);
    wr(`ART_IDX_PWM_CTRL, 8'h33);
    @(negedge ref_clk);
    chk(pulse_out_pin[1], !p);
    @(posedge ref_clk);
    wr(`ART_IDX_PWM_CTRL, 8'h03);
    @(negedge ref_clk);
    chk({pulse_out_oe, pulse_out_pin}, 4'h0);
    @(posedge ref_clk);
    $display("pwm done");
    wr(`ART_IDX_COUNTER, 8'h55);
    wr(`ART_IDX_CAPTURE_CS, 8'h1c);
    capture_pin <= 2'b01;
    repeat (3) @(posedge ref_clk);
    chk(capture_irq, 2'b01);
    capture_pin <= 2'b11;
    repeat (3) @(posedge ref_clk);
    rc(`ART_IDX_CAPTURE_CS, 8'h1d);
    rc(`ART_IDX_CAPTURE1, 8'h55);
    rc(`ART_IDX_CAPTURE_CS, 8'h1c);
    wr(`ART_IDX_CAPTURE1, 8'haa);
    rc(`ART_IDX_CAPTURE1, 8'h55);
    wr(`ART_IDX_COUNTER, 8'h66);
    wr(`ART_IDX_CAPTURE_CS, 8'h14);
    capture_pin <= 2'b01;
    repeat (3) @(posedge ref_clk);
    chk(capture_irq, 2'b00);
    rc(`ART_IDX_CAPTURE_CS, 8'h16);
    rc(`ART_IDX_CAPTURE2, 8'h66);
    wr(`ART_IDX_CAPTURE_CS, 8'hff);
    rc(`ART_IDX_CAPTURE_CS, 8'h3c);
    $display("capture done");
    report_and_stop();
  end
endmodule
